// file: lsc_regs.svh
// Register map, field positions, reset values and timing figures of the light sensor core
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH

// System clock rate and time bases
`define LSC_CLK_HZ          40000000
`define LSC_TICK_US         1000
`define LSC_TIMEOUT_MS      25

// Register addresses behind the pointer
`define LSC_ADDR_CTRL       4'h0
`define LSC_ADDR_CFG        4'h1
`define LSC_ADDR_CNT_LO     4'h4
`define LSC_ADDR_CNT_HI     4'h5
`define LSC_ADDR_ID         4'hA
`define LSC_PTR_JUMP_FROM   4'h0
`define LSC_PTR_WRAP_FROM   4'hD
`define LSC_PTR_STEP        4'h1

// Pointer byte fields
`define LSC_CMD_SEL_BIT     7
`define LSC_CMD_ADDR_MSB    3

// Control and configuration fields
`define LSC_CTRL_MODE_MSB   1
`define LSC_CFG_BYPASS_BIT  3
`define LSC_CFG_TSEL_MSB    1

// Operating modes and integration select codes
`define LSC_MODE_DOWN       2'h0
`define LSC_MODE_SINGLE     2'h2
`define LSC_MODE_CONT       2'h3
`define LSC_TSEL_RSVD       2'h3
`define LSC_TSEL_FAST       2'h2

// Reset values and base intervals in milliseconds
`define LSC_RESET_BYTE      8'h00
`define LSC_RESET_PTR       4'h0
`define LSC_RESET_COUNT     16'h0000
`define LSC_TINT_BASE_MS    9'h190
`define LSC_PSAVE_BASE_MS   9'h03C

// Serial framing
`define LSC_BITS_PER_BYTE   4'h8
`define LSC_LAST_TX_BIT     4'h7
`define LSC_DEV_ADDR        7'h29

`endif

// file: lsc_pkg.sv
// Types shared by the light sensor core modules
package lsc_pkg;

	// Serial target sequencing
	typedef enum logic [2:0] {
		LSC_BUS_IDLE,
		LSC_BUS_ADDR,
		LSC_BUS_ADDR_ACK,
		LSC_BUS_WR_BYTE,
		LSC_BUS_WR_ACK,
		LSC_BUS_RD_BYTE,
		LSC_BUS_RD_ACK
	} lsc_bus_state_t;

	// Acquisition sequencing
	typedef enum logic [1:0] {
		LSC_CONV_IDLE,
		LSC_CONV_INTEG,
		LSC_CONV_SAVE
	} lsc_conv_state_t;

endpackage : lsc_pkg

// file: lsc_conv.sv
// Acquisition sequencer: integration timing, power-save gaps and result capture
`timescale 1ns/100ps
`include "lsc_regs.svh"

module lsc_conv
	import lsc_pkg::*;
#(
	parameter int TICK_CYCLES = `LSC_CLK_HZ / 1000000 * `LSC_TICK_US
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [1:0]  mode,
	input  wire logic [1:0]  tsel,
	input  wire logic        bypass,
	input  wire logic [15:0] fe_result,
	output logic             fe_integrate,
	output logic             conv_done,
	output logic             single_done,
	output logic [15:0]      sample_data
);

	lsc_conv_state_t st_reg, st_next;
	logic [15:0] tick_cnt_reg, tick_cnt_next;
	logic [8:0]  ms_cnt_reg, ms_cnt_next;
	logic [15:0] sample_reg, sample_next;
	logic        done_reg, done_next;
	logic        single_reg, single_next;
	logic        integ_reg, integ_next;
	logic        tick;
	logic        run;
	logic [1:0]  tsel_eff;
	logic [8:0]  tint_ms;
	logic [8:0]  psave_ms;

	// Millisecond time base runs from the system clock, not from the bus
	always_comb begin
		tick        = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
		run         = (mode == `LSC_MODE_SINGLE) || (mode == `LSC_MODE_CONT);
		tsel_eff    = (tsel == `LSC_TSEL_RSVD) ? `LSC_TSEL_FAST : tsel; // Reserved code runs fastest
		tint_ms     = `LSC_TINT_BASE_MS >> tsel_eff;
		psave_ms    = `LSC_PSAVE_BASE_MS >> tsel_eff;
		st_next     = st_reg;
		ms_cnt_next = ms_cnt_reg;
		sample_next = sample_reg;
		done_next   = 1'b0;
		single_next = 1'b0;
		tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
		case (st_reg)
			LSC_CONV_IDLE: begin
				// Hold the prescaler so the first millisecond is a full one
				tick_cnt_next = 16'h0000;
				ms_cnt_next   = 9'h000;
				// A finished single shot waits here until its mode has cleared
				if (run && !single_reg) begin
					st_next = LSC_CONV_INTEG;
				end
			end
			LSC_CONV_INTEG: begin
				if (!run) begin
					st_next = LSC_CONV_IDLE;
				end else if (tick) begin
					if (ms_cnt_reg == tint_ms - 9'h001) begin
						sample_next = fe_result;
						done_next   = 1'b1;
						ms_cnt_next = 9'h000;
						if (mode == `LSC_MODE_SINGLE) begin
							single_next = 1'b1;
							st_next     = LSC_CONV_IDLE;
						end else if (bypass) begin
							st_next = LSC_CONV_INTEG;
						end else begin
							st_next = LSC_CONV_SAVE;
						end
					end else begin
						ms_cnt_next = ms_cnt_reg + 9'h001;
					end
				end
			end
			LSC_CONV_SAVE: begin
				if (mode != `LSC_MODE_CONT) begin
					st_next = LSC_CONV_IDLE;
				end else if (tick) begin
					if (ms_cnt_reg == psave_ms - 9'h001) begin
						ms_cnt_next = 9'h000;
						st_next     = LSC_CONV_INTEG;
					end else begin
						ms_cnt_next = ms_cnt_reg + 9'h001;
					end
				end
			end
			default: begin
				st_next = LSC_CONV_IDLE;
			end
		endcase
		integ_next = (st_next == LSC_CONV_INTEG);
	end

	// Sequencer registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg       <= LSC_CONV_IDLE;
			tick_cnt_reg <= 16'h0000;
			ms_cnt_reg   <= 9'h000;
			sample_reg   <= `LSC_RESET_COUNT;
			done_reg     <= 1'b0;
			single_reg   <= 1'b0;
			integ_reg    <= 1'b0;
		end else begin
			st_reg       <= st_next;
			tick_cnt_reg <= tick_cnt_next;
			ms_cnt_reg   <= ms_cnt_next;
			sample_reg   <= sample_next;
			done_reg     <= done_next;
			single_reg   <= single_next;
			integ_reg    <= integ_next;
		end
	end

	assign fe_integrate = integ_reg;
	assign conv_done    = done_reg;
	assign single_done  = single_reg;
	assign sample_data  = sample_reg;

endmodule : lsc_conv

// file: lsc_core.sv
// Light sensor digital core: serial target, pointer, register file and count buffering
`timescale 1ns/100ps
`include "lsc_regs.svh"

module lsc_core
	import lsc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR       = `LSC_DEV_ADDR,
	parameter logic [3:0] PART_ID        = 4'h5, // Arbitrary value
	parameter int         TICK_CYCLES    = `LSC_CLK_HZ / 1000000 * `LSC_TICK_US,
	parameter int         TIMEOUT_CYCLES = `LSC_CLK_HZ / 1000 * `LSC_TIMEOUT_MS
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic [15:0] fe_result,
	output logic             fe_integrate
);

	logic scl_meta, scl_sync, scl_prev;
	logic sda_meta, sda_sync, sda_prev;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	lsc_bus_state_t bst_reg, bst_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [7:0]  shift_reg, shift_next;
	logic [7:0]  tx_reg, tx_next;
	logic        oe_reg, oe_next;
	logic        rw_reg, rw_next;
	logic        ack_reg, ack_next;
	logic        first_reg, first_next;
	logic [3:0]  ptr_reg, ptr_next;
	logic        wr_en;
	logic [7:0]  rd_byte;

	logic [1:0]  mode_reg, mode_next;
	logic [1:0]  tsel_reg, tsel_next;
	logic        bypass_reg, bypass_next;
	logic [15:0] count_reg, count_next;
	logic [15:0] pend_reg, pend_next;
	logic        pend_valid_reg, pend_valid_next;
	logic        busy_reg, busy_next;

	logic [19:0] to_cnt_reg, to_cnt_next;
	logic        timeout;

	logic        conv_done, single_done;
	logic [15:0] sample_data;

	// Read pointer advance jumps from CTRL straight to ID and wraps from 0xD back to CTRL
	function automatic logic [3:0] lsc_ptr_adv(input logic [3:0] p);
		if (p == `LSC_PTR_JUMP_FROM) begin
			lsc_ptr_adv = `LSC_ADDR_ID;
		end else if (p == `LSC_PTR_WRAP_FROM) begin
			lsc_ptr_adv = `LSC_PTR_JUMP_FROM;
		end else begin
			lsc_ptr_adv = p + `LSC_PTR_STEP;
		end
	endfunction : lsc_ptr_adv

	// Two-flop synchronisers, then one more stage for edge detection
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			scl_prev <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_meta <= scl_in;
			scl_sync <= scl_meta;
			scl_prev <= scl_sync;
			sda_meta <= sda_in;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
		end
	end

	// Bus conditions seen on the synchronised lines
	assign scl_rise  = scl_sync & ~scl_prev;
	assign scl_fall  = ~scl_sync & scl_prev;
	assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
	assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

	// Unimplemented addresses read as zero; reserved bits read as zero
	always_comb begin
		case (ptr_reg)
			`LSC_ADDR_CTRL:   rd_byte = {6'h00, mode_reg};
			`LSC_ADDR_CFG:    rd_byte = {4'h0, bypass_reg, 1'b0, tsel_reg};
			`LSC_ADDR_CNT_LO: rd_byte = count_reg[7:0];
			`LSC_ADDR_CNT_HI: rd_byte = count_reg[15:8];
			`LSC_ADDR_ID:     rd_byte = {PART_ID, 4'h0};
			default:          rd_byte = `LSC_RESET_BYTE;
		endcase
	end

	// Bus-low timeout counter; saturates so the interface stays idle while stuck
	always_comb begin
		timeout = (to_cnt_reg == 20'(TIMEOUT_CYCLES - 1));
		if (scl_sync && sda_sync) begin
			to_cnt_next = 20'h00000;
		end else if (timeout) begin
			to_cnt_next = to_cnt_reg;
		end else begin
			to_cnt_next = to_cnt_reg + 20'h00001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			to_cnt_reg <= 20'h00000;
		end else begin
			to_cnt_reg <= to_cnt_next;
		end
	end

	// Serial target: bits sampled on SCL rise, SDA changed only after SCL fall
	always_comb begin
		bst_next   = bst_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		tx_next    = tx_reg;
		oe_next    = oe_reg;
		rw_next    = rw_reg;
		ack_next   = ack_reg;
		first_next = first_reg;
		ptr_next   = ptr_reg;
		wr_en      = 1'b0;
		if (timeout) begin
			bst_next = LSC_BUS_IDLE;
			oe_next  = 1'b0;
		end else if (bus_start) begin
			bst_next = LSC_BUS_ADDR;
			cnt_next = 4'h0;
			oe_next  = 1'b0;
		end else if (bus_stop) begin
			bst_next = LSC_BUS_IDLE;
			oe_next  = 1'b0;
		end else begin
			case (bst_reg)
				LSC_BUS_IDLE: begin
					oe_next = 1'b0;
				end
				LSC_BUS_ADDR: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_sync};
						cnt_next   = cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == `LSC_BITS_PER_BYTE) begin
						cnt_next = 4'h0;
						if (shift_reg[7:1] == DEV_ADDR) begin
							bst_next = LSC_BUS_ADDR_ACK;
							oe_next  = 1'b1;
							rw_next  = shift_reg[0];
						end else begin
							bst_next = LSC_BUS_IDLE;
						end
					end
				end
				LSC_BUS_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_next = 4'h0;
						if (rw_reg) begin
							tx_next  = rd_byte;
							oe_next  = ~rd_byte[7];
							ptr_next = lsc_ptr_adv(ptr_reg);
							bst_next = LSC_BUS_RD_BYTE;
						end else begin
							oe_next    = 1'b0;
							first_next = 1'b1;
							bst_next   = LSC_BUS_WR_BYTE;
						end
					end
				end
				LSC_BUS_WR_BYTE: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_sync};
						cnt_next   = cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == `LSC_BITS_PER_BYTE) begin
						oe_next    = 1'b1;
						first_next = 1'b0;
						bst_next   = LSC_BUS_WR_ACK;
						if (first_reg && shift_reg[`LSC_CMD_SEL_BIT]) begin
							ptr_next = shift_reg[`LSC_CMD_ADDR_MSB:0];
						end else begin
							wr_en    = 1'b1;
							ptr_next = ptr_reg + `LSC_PTR_STEP;
						end
					end
				end
				LSC_BUS_WR_ACK: begin
					if (scl_fall) begin
						oe_next  = 1'b0;
						cnt_next = 4'h0;
						bst_next = LSC_BUS_WR_BYTE;
					end
				end
				LSC_BUS_RD_BYTE: begin
					if (scl_fall) begin
						if (cnt_reg == `LSC_LAST_TX_BIT) begin
							oe_next  = 1'b0;
							bst_next = LSC_BUS_RD_ACK;
						end else begin
							tx_next  = {tx_reg[6:0], 1'b0};
							oe_next  = ~tx_reg[6];
							cnt_next = cnt_reg + 4'h1;
						end
					end
				end
				LSC_BUS_RD_ACK: begin
					if (scl_rise) begin
						ack_next = ~sda_sync;
					end else if (scl_fall) begin
						cnt_next = 4'h0;
						if (ack_reg) begin
							tx_next  = rd_byte;
							oe_next  = ~rd_byte[7];
							ptr_next = lsc_ptr_adv(ptr_reg);
							bst_next = LSC_BUS_RD_BYTE;
						end else begin
							bst_next = LSC_BUS_IDLE;
						end
					end
				end
				default: begin
					bst_next = LSC_BUS_IDLE;
					oe_next  = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bst_reg   <= LSC_BUS_IDLE;
			cnt_reg   <= 4'h0;
			shift_reg <= `LSC_RESET_BYTE;
			tx_reg    <= `LSC_RESET_BYTE;
			oe_reg    <= 1'b0;
			rw_reg    <= 1'b0;
			ack_reg   <= 1'b0;
			first_reg <= 1'b0;
			ptr_reg   <= `LSC_RESET_PTR;
		end else begin
			bst_reg   <= bst_next;
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
			tx_reg    <= tx_next;
			oe_reg    <= oe_next;
			rw_reg    <= rw_next;
			ack_reg   <= ack_next;
			first_reg <= first_next;
			ptr_reg   <= ptr_next;
		end
	end

	// Register file and double-buffered count
	always_comb begin
		mode_next       = mode_reg;
		tsel_next       = tsel_reg;
		bypass_next     = bypass_reg;
		count_next      = count_reg;
		pend_next       = pend_reg;
		pend_valid_next = pend_valid_reg;
		busy_next       = busy_reg;
		// A host write wins over the self-clear of single mode
		if (wr_en && ptr_reg == `LSC_ADDR_CTRL) begin
			mode_next = shift_reg[`LSC_CTRL_MODE_MSB:0];
		end else if (single_done) begin
			mode_next = `LSC_MODE_DOWN;
		end
		if (wr_en && ptr_reg == `LSC_ADDR_CFG) begin
			tsel_next   = shift_reg[`LSC_CFG_TSEL_MSB:0];
			bypass_next = shift_reg[`LSC_CFG_BYPASS_BIT];
		end
		if (bus_start) begin
			busy_next = 1'b1;
		end else if (bus_stop || timeout) begin
			busy_next = 1'b0;
		end
		// Copy only between transactions, so a pair read in one transfer is coherent
		if (pend_valid_reg && !busy_reg) begin
			count_next      = pend_reg;
			pend_valid_next = 1'b0;
		end
		if (conv_done) begin
			pend_next       = sample_data;
			pend_valid_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg       <= `LSC_MODE_DOWN;
			tsel_reg       <= 2'h0;
			bypass_reg     <= 1'b0;
			count_reg      <= `LSC_RESET_COUNT;
			pend_reg       <= `LSC_RESET_COUNT;
			pend_valid_reg <= 1'b0;
			busy_reg       <= 1'b0;
		end else begin
			mode_reg       <= mode_next;
			tsel_reg       <= tsel_next;
			bypass_reg     <= bypass_next;
			count_reg      <= count_next;
			pend_reg       <= pend_next;
			pend_valid_reg <= pend_valid_next;
			busy_reg       <= busy_next;
		end
	end

	// Acquisition sequencer
	lsc_conv #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_conv (
		.clk_sys      (clk_sys),
		.rst_n        (rst_n),
		.mode         (mode_reg),
		.tsel         (tsel_reg),
		.bypass       (bypass_reg),
		.fe_result    (fe_result),
		.fe_integrate (fe_integrate),
		.conv_done    (conv_done),
		.single_done  (single_done),
		.sample_data  (sample_data)
	);

	// Open-drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe  = oe_reg;

endmodule : lsc_core

// file: lsc_host.sv
// Serial bus host model for the light sensor core
`timescale 1ns/100ps

module lsc_host (
	input  wire logic clk_sys,
	input  wire logic sda_line,
	output logic      scl_drv,
	output logic      sda_drv
);
	// Both lines rest high; the clock only moves inside frames
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : w

	// Data changes mid-low phase so it never moves while the clock is high
	task automatic bit_io(input logic b, output logic s);
		sda_drv <= b;
		w(2);
		scl_drv <= 1'b1;
		w(3);
		@(negedge clk_sys) s = sda_line;
		w(1);
		scl_drv <= 1'b0;
		w(2);
	endtask : bit_io

	// Byte MSB first, then the acknowledge slot (a high releases it)
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic ak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, ak);
	endtask : xfer

	// Start or repeated start
	task automatic start();
		sda_drv <= 1'b1;
		w(2);
		scl_drv <= 1'b1;
		w(4);
		sda_drv <= 1'b0;
		w(4);
		scl_drv <= 1'b0;
		w(2);
	endtask : start

	task automatic stop();
		sda_drv <= 1'b0;
		w(2);
		scl_drv <= 1'b1;
		w(4);
		sda_drv <= 1'b1;
		w(4);
	endtask : stop

	// Both lines high without a stop, so the frame stays open
	task automatic park(input int n);
		sda_drv <= 1'b1;
		w(2);
		scl_drv <= 1'b1;
		w(n);
	endtask : park

	// Clock held low to stall the bus
	task automatic stall(input int n);
		scl_drv <= 1'b0;
		w(n);
	endtask : stall
endmodule : lsc_host

// file: lsc_core_checker.sv
// Pin-level assertions for the light sensor core
`timescale 1ns/100ps

module lsc_core_checker #(
	parameter int TICK_CYCLES    = 4,
	parameter int TIMEOUT_CYCLES = 200
) (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic [15:0] fe_result,
	input wire logic        fe_integrate
);
	localparam int T1 = 100 * TICK_CYCLES;
	localparam int T2 = 200 * TICK_CYCLES;
	localparam int T4 = 400 * TICK_CYCLES;
	int hi_cnt_reg;
	int low_cnt_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Integration pulse length and line-low stretch, counted in clocks
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt_reg  <= 0;
			low_cnt_reg <= 0;
		end else begin
			hi_cnt_reg  <= fe_integrate ? hi_cnt_reg + 1 : 0;
			low_cnt_reg <= (!scl_in || !sda_in) ? low_cnt_reg + 1 : 0;
		end
	end

	sequence s_start;
		scl_in && $fell(sda_in);
	endsequence
	sequence s_stop;
		scl_in && $rose(sda_in);
	endsequence

	a_reset_quiet: assert property ($rose(rst_n) |-> (!sda_oe && !fe_integrate) [*8])
		else $error("outputs active right after reset");
	a_stable_high: assert property (scl_in [*4] |-> $stable(sda_oe))
		else $error("data driver moved while clock high");
	a_start_silent: assert property (s_start |-> !sda_oe [*8])
		else $error("data driven during address phase");
	a_stop_release: assert property (s_stop |=> !sda_oe [*4])
		else $error("data driven after stop");
	a_idle_quiet: assert property (scl_in [*8] |-> !sda_oe)
		else $error("data driven on a resting bus");
	// Margin covers the input synchronisers ahead of the timeout counter
	a_timeout_free: assert property (low_cnt_reg >= TIMEOUT_CYCLES + 12 |-> !sda_oe)
		else $error("bus not freed after low timeout");
	a_integ_len: assert property ($fell(fe_integrate) |->
		hi_cnt_reg inside {[T1 - 2:T1 + 2], [T2 - 2:T2 + 2], [T4 - 2:T4 + 2]})
		else $error("integration length off");
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
endmodule : lsc_core_checker

bind lsc_core lsc_core_checker #(
	.TICK_CYCLES    (TICK_CYCLES),
	.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
) u_checker (
	.clk_sys      (clk_sys),
	.rst_n        (rst_n),
	.scl_in       (scl_in),
	.sda_in       (sda_in),
	.sda_out      (sda_out),
	.sda_oe       (sda_oe),
	.fe_result    (fe_result),
	.fe_integrate (fe_integrate)
);

// file: lsc_core_test.sv
// Self-checking bench for the light sensor core
`timescale 1ns/100ps
`include "lsc_regs.svh"

module lsc_core_test;
	localparam int         TICK = 4;
	localparam int         TMO  = 480; // Above the longest all-zero stretch of a read
	localparam logic [3:0] PID  = 4'h6; // Arbitrary value

	logic        clk_sys;
	logic        rst_n;
	logic        scl_drv;
	logic        sda_drv;
	logic        sda_oe;
	logic        sda_out;
	logic [15:0] fe_result;
	logic        fe_integrate;
	int          err_total, checked, cyc, hi_n, last_hi, falls, per_n, last_per, rises;
	// Open-drain wire with pull-up
	wire         sda_line = sda_drv & ~(sda_oe & ~sda_out);

	lsc_host hm (
		.clk_sys  (clk_sys),
		.sda_line (sda_line),
		.scl_drv  (scl_drv),
		.sda_drv  (sda_drv)
	);

	lsc_core #(
		.PART_ID        (PID),
		.TICK_CYCLES    (TICK),
		.TIMEOUT_CYCLES (TMO)
	) dut (
		.clk_sys      (clk_sys),
		.rst_n        (rst_n),
		.scl_in       (scl_drv),
		.sda_in       (sda_line),
		.sda_out      (sda_out),
		.sda_oe       (sda_oe),
		.fe_result    (fe_result),
		.fe_integrate (fe_integrate)
	);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Pulse lengths and rise spacing; a hang is cut short here
	always @(posedge clk_sys) begin
		cyc++;
		per_n++;
		if (fe_integrate) begin
			hi_n++;
			if (hi_n == 1) begin
				last_per = per_n;
				per_n = 0;
				rises++;
			end
		end else if (hi_n != 0) begin
			last_hi = hi_n;
			hi_n = 0;
			falls++;
		end
		if (cyc == 80000) begin
			err_total++;
			summarize();
		end
	end

	// Expected cycle length in clocks; byp high leaves out the gap, code 11 runs as 10
	function automatic int cyc_len(input logic [1:0] ts, input logic byp);
		int sh;
		sh = (ts == 2'h3) ? 2 : int'(ts);
		// Gap is 60 ms over the scale factor of 1, 2 or 4
		return ((400 >> sh) + (byp ? 0 : (60 >> sh))) * TICK;
	endfunction : cyc_len

	function automatic logic near(input int a, input int b);
		return (a - b <= 2) && (b - a <= 2);
	endfunction : near

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Write frame; fin low leaves it open for a repeated start
	task automatic put(input logic [7:0] b[$], input logic fin);
		logic [7:0] q;
		logic       ak;
		hm.start();
		hm.xfer({`LSC_DEV_ADDR, 1'b0}, 1'b1, q, ak);
		check("addr ack", ak, 1'b0);
		foreach (b[i]) begin
			hm.xfer(b[i], 1'b1, q, ak);
			check("data ack", ak, 1'b0);
		end
		if (fin) hm.stop();
	endtask : put

	// Read as many bytes as listed, last one refused
	task automatic get(input logic [7:0] e[$], input string nm);
		logic [7:0] q;
		logic       ak;
		hm.start();
		hm.xfer({`LSC_DEV_ADDR, 1'b1}, 1'b1, q, ak);
		check("read ack", ak, 1'b0);
		foreach (e[i]) begin
			hm.xfer(8'hFF, i == e.size() - 1, q, ak);
			check(nm, q, e[i]);
		end
		hm.stop();
	endtask : get

	task automatic summarize();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	initial begin
		logic [15:0] r, r2;
		logic [7:0]  c;
		logic [1:0]  ts;
		logic        ak;
		int          n0, lows;
		void'($urandom(15596));
		rst_n     = 1'b0;
		fe_result = 16'h0000;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		// Reset values and the read pointer's skip pattern
		put('{8'h80}, 1'b0);
		get('{8'h00, {PID, 4'h0}, 8'h00, 8'h00, 8'h00, 8'h00}, "walk");
		put('{8'h84, 8'hFF, 8'h5A}, 1'b1);
		put('{8'h81}, 1'b0);
		get('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, "regs");
		// Foreign address is ignored
		hm.start();
		hm.xfer({~`LSC_DEV_ADDR, 1'b0}, 1'b1, c, ak);
		check("foreign", ak, 1'b1);
		hm.stop();
		// Single shots over every integration select code, reserved bits randomised
		for (int k = 0; k < 4; k++) begin
			c  = 8'($urandom);
			ts = 2'(k);
			r  = 16'($urandom);
			fe_result <= r;
			put('{{1'b1, c[6:4], 4'h1}, {c[7:2], ts}}, 1'b1);
			put('{8'h81}, 1'b0);
			get('{{4'h0, c[3], 1'b0, ts}}, "config");
			put('{8'h80}, 1'b1);
			put('{8'h02}, 1'b1);
			n0 = falls;
			while (falls == n0) @(posedge clk_sys);
			check("integ", near(last_hi, cyc_len(ts, 1'b1)), 1'b1);
			put('{8'h80}, 1'b0);
			get('{8'h00}, "mode");
			put('{8'h84}, 1'b1);
			get('{r[7:0], r[15:8]}, "count");
			check("down", fe_integrate, 1'b0);
		end
		// New count is held back while a frame stays open
		r2 = 16'($urandom);
		fe_result <= r2;
		put('{8'h80, 8'h02}, 1'b1);
		put('{8'h84}, 1'b0);
		n0 = falls;
		hm.park(2);
		while (falls == n0) @(posedge clk_sys);
		hm.park(20);
		get('{r[7:0], r[15:8]}, "held");
		put('{8'h84}, 1'b1);
		get('{r2[7:0], r2[15:8]}, "fresh");
		// Clock stuck low in mid-read must free the data line
		put('{8'h80}, 1'b0);
		hm.start();
		hm.xfer({`LSC_DEV_ADDR, 1'b1}, 1'b1, c, ak);
		hm.stall(TMO - 20);
		#1;
		check("early", sda_oe, 1'b1);
		hm.stall(60);
		#1;
		check("freed", sda_oe, 1'b0);
		hm.stop();
		// Reserved mode stays powered down
		put('{8'h80, 8'h01}, 1'b1);
		repeat (50) @(posedge clk_sys);
		check("rsvd", fe_integrate, 1'b0);
		// Continuous run with the power-save gap, then without it
		put('{8'h81, 8'h02}, 1'b1);
		put('{8'h80, 8'h03}, 1'b1);
		n0 = rises;
		while (rises < n0 + 2) @(posedge clk_sys);
		check("period", near(last_per, cyc_len(2'h2, 1'b0)), 1'b1);
		put('{8'h81, 8'h0A}, 1'b1);
		repeat (3 * 100 * TICK) @(posedge clk_sys);
		lows = 0;
		repeat (2 * 100 * TICK) begin
			@(posedge clk_sys);
			lows += int'(!fe_integrate);
		end
		check("gapless", lows <= 4, 1'b1);
		summarize();
	end
endmodule : lsc_core_test
